// file: rtl/ram_pkg.sv
// shared constants and types for the dual-port embedded ram block
package ram_pkg;
    // block clocking configurations
    typedef enum logic [1:0] {
        MODE_INDEP,
        MODE_INOUT,
        MODE_RDWR,
        MODE_SINGLE
    } mode_e;

    localparam int LANE_W    = 9;
    localparam int LANES     = 4;
    localparam int DATA_W    = LANE_W * LANES;
    localparam int ADDR_W    = 7;
    localparam int DEPTH     = 1 << ADDR_W;
    // largest ram that may share a block with a second one, in bits
    localparam int HALF_BITS = 2048;
    // address bit that splits the array into two single-port halves
    localparam int HALF_BIT  = ADDR_W - 1;
    localparam logic HALF_LOW  = 1'h0;
    localparam logic HALF_HIGH = 1'h1;
endpackage

// file: rtl/ram_port_if.sv
// signals between the array core and one port's register stage
`timescale 1ns/1ps
interface ram_port_if #(
    parameter int AW = ram_pkg::ADDR_W,
    parameter int DW = ram_pkg::DATA_W,
    parameter int LN = ram_pkg::LANES
);
    logic          in_tick;
    logic          out_tick;
    logic          in_en;
    logic          out_en;
    logic          in_clr;
    logic          out_clr;
    logic          keep_re;
    logic          bypass;
    logic [AW-1:0] addr;
    logic [DW-1:0] wdata;
    logic [LN-1:0] lanes;
    logic          we;
    logic          re;
    logic [DW-1:0] rd_word;
    logic          acc;
    logic [AW-1:0] acc_addr;
    logic [DW-1:0] acc_data;
    logic [LN-1:0] acc_lanes;
    logic          acc_we;
    logic          acc_re;
    logic [DW-1:0] dout;

    modport core (
        output in_tick, out_tick, in_en, out_en, in_clr, out_clr,
        output keep_re, bypass, addr, wdata, lanes, we, re, rd_word,
        input  acc, acc_addr, acc_data, acc_lanes, acc_we, acc_re, dout
    );
    modport port (
        input  in_tick, out_tick, in_en, out_en, in_clr, out_clr,
        input  keep_re, bypass, addr, wdata, lanes, we, re, rd_word,
        output acc, acc_addr, acc_data, acc_lanes, acc_we, acc_re, dout
    );
endinterface // ram_port_if

// file: rtl/ram_port.sv
// input and output register stage of one ram port
`timescale 1ns/1ps
module ram_port #(
    parameter int AW = ram_pkg::ADDR_W,
    parameter int DW = ram_pkg::DATA_W,
    parameter int LN = ram_pkg::LANES
) (
    input wire logic CLK,
    input wire logic SYS_RST,
    ram_port_if.port p
);
    typedef struct packed {
        logic [AW-1:0] addr;
        logic [DW-1:0] data;
        logic [LN-1:0] lanes;
        logic          we;
        logic          re;
        logic          acc;
        logic [DW-1:0] raw;
        logic [DW-1:0] out;
    } port_s;

    port_s state_reg;
    port_s state_next;
    logic  capture;

    assign capture = p.in_tick & p.in_en;

    always_comb begin
        state_next = state_reg;
        state_next.acc = 1'h0;
        if (capture) begin
            state_next.addr  = p.addr;
            state_next.data  = p.wdata;
            state_next.lanes = p.lanes;
            state_next.we    = p.we;
            state_next.re    = p.re;
            state_next.acc   = 1'h1;
        end
        if (state_reg.acc && state_reg.re) begin
            state_next.raw = p.rd_word;
            if (p.bypass) begin
                state_next.out = p.rd_word;
            end
        end
        if (p.out_tick && p.out_en && !p.bypass) begin
            state_next.out = state_reg.raw;
        end
        if (p.in_clr) begin
            state_next.addr  = '0;
            state_next.data  = '0;
            state_next.lanes = '0;
            state_next.we    = 1'h0;
            state_next.acc   = 1'h0;
            if (!p.keep_re) begin
                state_next.re = 1'h0;
            end
        end
        if (p.out_clr) begin
            state_next.raw = '0;
            state_next.out = '0;
        end
    end

    always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign p.acc       = state_reg.acc;
    assign p.acc_addr  = state_reg.addr;
    assign p.acc_data  = state_reg.data;
    assign p.acc_lanes = state_reg.lanes;
    assign p.acc_we    = state_reg.we;
    assign p.acc_re    = state_reg.re;
    assign p.dout      = state_reg.out;

    default clocking cb @(posedge CLK); endclocking
    default disable iff (SYS_RST);

    a_capture_addr: assert property (capture && !p.in_clr |=>
        p.acc && p.acc_addr == $past(p.addr) && p.acc_we == $past(p.we))
        else $error("port did not capture its inputs");
    a_enable_hold: assert property (!p.in_en && !p.in_clr |=>
        $stable(p.acc_addr) && !p.acc)
        else $error("input registers moved without enable");
    a_input_clear: assert property (p.in_clr |=>
        p.acc_addr == '0 && !p.acc_we && !p.acc)
        else $error("input clear did not zero registers");
    a_strobe_kept: assert property (p.in_clr && p.keep_re
        && !capture |=> p.acc_re == $past(p.acc_re))
        else $error("read strobe was cleared");
    a_output_clear: assert property (p.out_clr |=> p.dout == '0)
        else $error("output clear did not zero data out");
    a_output_hold: assert property (!(p.out_tick && p.out_en) &&
        !p.bypass && !p.out_clr |=> $stable(p.dout))
        else $error("output register moved without its tick");
    a_bypass_path: assert property (p.acc && p.acc_re && p.bypass &&
        !p.out_clr |=> p.dout == $past(p.rd_word))
        else $error("bypassed read data not delivered");

    c_read_bypass: cover property (p.acc && p.acc_re && p.bypass);
    c_read_piped: cover property (p.acc && p.acc_re ##[1:8]
        p.out_tick && p.out_en && !p.bypass);
endmodule // ram_port

// file: rtl/ram_block.sv
// embedded dual-port ram with selectable clocking configurations
`timescale 1ns/1ps
module ram_block #(
    parameter int AW = ram_pkg::ADDR_W,
    parameter int LW = ram_pkg::LANE_W,
    parameter int LN = ram_pkg::LANES
) (
    // clock and reset
    input  wire logic                 CLK,
    input  wire logic                 SYS_RST,
    // configuration
    input  wire ram_pkg::mode_e       MODE,
    input  wire logic                 SIMPLE_DP,
    input  wire logic                 BYPASS_A,
    input  wire logic                 BYPASS_B,
    // the two block clock edges, as same-domain ticks
    input  wire logic                 TICK0,
    input  wire logic                 TICK1,
    // port A enables and clears
    input  wire logic                 EN_IN_A,
    input  wire logic                 EN_OUT_A,
    input  wire logic                 CLR_IN_A,
    input  wire logic                 CLR_OUT_A,
    // port B enables and clears
    input  wire logic                 EN_IN_B,
    input  wire logic                 EN_OUT_B,
    input  wire logic                 CLR_IN_B,
    input  wire logic                 CLR_OUT_B,
    // port A access
    input  wire logic [AW-1:0]        ADDR_A,
    input  wire logic [LW*LN-1:0]     WDATA_A,
    input  wire logic [LN-1:0]        LANES_A,
    input  wire logic                 WE_A,
    input  wire logic                 RE_A,
    output logic      [LW*LN-1:0]     DOUT_A,
    // port B access
    input  wire logic [AW-1:0]        ADDR_B,
    input  wire logic [LW*LN-1:0]     WDATA_B,
    input  wire logic [LN-1:0]        LANES_B,
    input  wire logic                 WE_B,
    input  wire logic                 RE_B,
    output logic      [LW*LN-1:0]     DOUT_B
);
    localparam int DW = LW * LN;
    localparam int DEPTH = 1 << AW;

    ram_port_if #(.AW(AW), .DW(DW), .LN(LN)) pa ();
    ram_port_if #(.AW(AW), .DW(DW), .LN(LN)) pb ();

    logic [DW-1:0] mem [DEPTH];
    logic          is_indep;
    logic          is_inout;
    logic          is_rdwr;
    logic          is_single;
    logic          simple;

    assign is_indep  = (MODE == ram_pkg::MODE_INDEP);
    assign is_inout  = (MODE == ram_pkg::MODE_INOUT);
    assign is_rdwr   = (MODE == ram_pkg::MODE_RDWR);
    assign is_single = (MODE == ram_pkg::MODE_SINGLE);
    assign simple    = is_rdwr | (is_inout & SIMPLE_DP);

    // port A follows clock A in one-clock-per-port modes
    assign pa.in_tick  = TICK0;
    // split output clock in in/out mode
    assign pa.out_tick = is_inout ? TICK1 : TICK0;
    // read side on the read clock, except its inputs, which take tick0 in in/out mode
    assign pb.in_tick  = is_inout ? TICK0 : TICK1;
    assign pb.out_tick = TICK1;

    // one enable and clear per port unless split
    assign pa.in_en   = EN_IN_A;
    assign pa.in_clr  = CLR_IN_A;
    assign pa.out_en  = is_inout ? EN_OUT_A : EN_IN_A;
    assign pa.out_clr = is_inout ? CLR_OUT_A : CLR_IN_A;
    // read side uses its own enable and clear
    assign pb.in_en   = EN_IN_B;
    assign pb.in_clr  = CLR_IN_B;
    assign pb.out_en  = is_inout ? EN_OUT_B : EN_IN_B;
    assign pb.out_clr = is_inout ? CLR_OUT_B : CLR_IN_B;

    // read strobe survives clears in simple dual-port use
    assign pa.keep_re = simple;
    assign pb.keep_re = simple;
    assign pa.bypass  = BYPASS_A;
    assign pb.bypass  = BYPASS_B;

    // single mode splits the array into two halves
    assign pa.addr = is_single ? {ram_pkg::HALF_LOW, ADDR_A[AW-2:0]}
                               : ADDR_A;
    assign pb.addr = is_single ? {ram_pkg::HALF_HIGH, ADDR_B[AW-2:0]}
                               : ADDR_B;
    assign pa.wdata = WDATA_A;
    assign pb.wdata = WDATA_B;
    assign pa.lanes = LANES_A;
    assign pb.lanes = LANES_B;
    // port A is the write side in simple dual-port use
    assign pa.we = WE_A;
    assign pa.re = simple ? 1'h0 : RE_A;
    assign pb.we = simple ? 1'h0 : WE_B;
    assign pb.re = RE_B;

    // read-before-write: a read and write to one word return the old data
    assign pa.rd_word = mem[pa.acc_addr];
    assign pb.rd_word = mem[pb.acc_addr];

    ram_port #(.AW(AW), .DW(DW), .LN(LN)) u_port_a (
        .CLK     (CLK),
        .SYS_RST (SYS_RST),
        .p       (pa)
    );

    ram_port #(.AW(AW), .DW(DW), .LN(LN)) u_port_b (
        .CLK     (CLK),
        .SYS_RST (SYS_RST),
        .p       (pb)
    );

    // the array has no reset so clears and reset never touch contents;
    // port B is applied last and wins a same-word collision
    always_ff @(posedge CLK) begin
        for (int i = 0; i < LN; i++) begin
            if (pa.acc && pa.acc_we && pa.acc_lanes[i]) begin
                mem[pa.acc_addr][i*LW +: LW] <= pa.acc_data[i*LW +: LW];
            end
            if (pb.acc && pb.acc_we && pb.acc_lanes[i]) begin
                mem[pb.acc_addr][i*LW +: LW] <= pb.acc_data[i*LW +: LW];
            end
        end
    end

    assign DOUT_A = pa.dout;
    assign DOUT_B = pb.dout;

    default clocking cb @(posedge CLK); endclocking
    default disable iff (SYS_RST);

    a_lane_write: assert property (pa.acc && pa.acc_we &&
        pa.acc_lanes[0] && !(pb.acc && pb.acc_we) |=>
        mem[$past(pa.acc_addr)][LW-1:0] == $past(pa.acc_data[LW-1:0]))
        else $error("enabled lane not written");
    a_single_half: assert property (is_single && TICK1 && EN_IN_B &&
        !CLR_IN_B |=> pb.acc_addr[AW-1] == ram_pkg::HALF_HIGH)
        else $error("second single-port ram left its half");
    a_write_side: assert property (is_rdwr && TICK0 && EN_IN_A &&
        !CLR_IN_A |=> pa.acc && !pa.acc_re)
        else $error("write side not captured on write clock");
    a_read_side: assert property (is_rdwr && TICK1 && EN_IN_B &&
        !CLR_IN_B |=> pb.acc && !pb.acc_we)
        else $error("read side not captured on read clock");
    a_read_enable: assert property (is_rdwr && !EN_IN_B && !CLR_IN_B
        && !BYPASS_B |=> $stable(DOUT_B))
        else $error("read output moved with read enable low");

    c_indep_both: cover property (is_indep && pa.acc && pb.acc);
    c_single_mode: cover property (is_single && pa.acc && pb.acc);
    c_rdwr_mode: cover property (is_rdwr && pa.acc && pa.acc_we
        ##[1:8] pb.acc && pb.acc_re);
endmodule // ram_block

// file: verification/fabric_port.sv
// fabric-side model driving the access lines of one ram port
`timescale 1ns/1ps
module fabric_port (
    // access lines toward one ram port
    output logic [ram_pkg::ADDR_W-1:0] addr,
    output logic [ram_pkg::DATA_W-1:0] wdata,
    output logic [ram_pkg::LANES-1:0]  lanes,
    output logic                       we,
    output logic                       re
);
    initial begin
        addr  = 7'h0;
        wdata = 36'h0;
        lanes = 4'h0;
        we    = 1'h0;
        re    = 1'h0;
    end

    // called just after a falling edge; held through the capture edge
    task automatic drive(input logic w, input logic r,
                         input logic [ram_pkg::ADDR_W-1:0] a,
                         input logic [ram_pkg::DATA_W-1:0] d,
                         input logic [ram_pkg::LANES-1:0] l);
        addr  = a;
        wdata = d;
        lanes = l;
        we    = w;
        re    = r;
    endtask

    // strobes low when idle
    // released lines turn over so a stale value never passes as valid
    task automatic idle();
        we    = 1'h0;
        re    = 1'h0;
        addr  = ~addr;
        wdata = ~wdata;
        lanes = ~lanes;
    endtask
endmodule // fabric_port

// file: verification/tb_dual_port_ram_clock_modes.sv
// self-checking bench for the dual-port ram block
`timescale 1ns/1ps
module tb_dual_port_ram_clock_modes;
    localparam int LW = ram_pkg::LANE_W;
    typedef logic [ram_pkg::DATA_W-1:0] word_t;
    typedef logic [ram_pkg::ADDR_W-1:0] addr_t;
    localparam logic  ON  = 1'h1;
    localparam logic  OFF = 1'h0;
    localparam word_t W1  = 36'h123456789;
    localparam word_t W2  = 36'hfedcba987;
    localparam word_t W3  = 36'h0f0f0f0f0;
    logic clk = 1'h0, rst = 1'h1, sdp = 1'h0, byp_a = 1'h1, byp_b = 1'h1;
    logic t0 = 1'h0, t1 = 1'h0;
    logic en_ia = 1'h1, en_oa = 1'h1, clr_ia = 1'h0, clr_oa = 1'h0;
    logic en_ib = 1'h1, en_ob = 1'h1, clr_ib = 1'h0, clr_ob = 1'h0;
    ram_pkg::mode_e mode = ram_pkg::MODE_INDEP;
    addr_t a_ad, b_ad;
    word_t a_wd, b_wd, dout_a, dout_b;
    logic [3:0] a_ln, b_ln;
    logic a_we, a_re, b_we, b_re;
    int num_errors = 0;
    int cmp_count = 0;

    always #20 clk = ~clk;

    ram_block dut_u (.CLK(clk), .SYS_RST(rst), .MODE(mode), .SIMPLE_DP(sdp),
        .BYPASS_A(byp_a), .BYPASS_B(byp_b), .TICK0(t0), .TICK1(t1),
        .EN_IN_A(en_ia), .EN_OUT_A(en_oa), .CLR_IN_A(clr_ia),
        .CLR_OUT_A(clr_oa), .EN_IN_B(en_ib), .EN_OUT_B(en_ob),
        .CLR_IN_B(clr_ib), .CLR_OUT_B(clr_ob), .ADDR_A(a_ad),
        .WDATA_A(a_wd), .LANES_A(a_ln), .WE_A(a_we), .RE_A(a_re),
        .DOUT_A(dout_a), .ADDR_B(b_ad), .WDATA_B(b_wd), .LANES_B(b_ln),
        .WE_B(b_we), .RE_B(b_re), .DOUT_B(dout_b));
    fabric_port pa (.addr(a_ad), .wdata(a_wd), .lanes(a_ln), .we(a_we),
        .re(a_re));
    fabric_port pb (.addr(b_ad), .wdata(b_wd), .lanes(b_ln), .we(b_we),
        .re(b_re));

    task automatic final_report();
        $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    task automatic step();
        @(posedge clk);
        @(negedge clk);
    endtask

    task automatic chk(input string what, input word_t exp, input word_t got);
        cmp_count++;
        if (got !== exp) begin
            num_errors++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask

    function automatic word_t merge(word_t o, word_t n, logic [3:0] l);
        word_t m;
        m = o;
        for (int i = 0; i < ram_pkg::LANES; i++)
            if (l[i]) m[i*LW +: LW] = n[i*LW +: LW];
        return m;
    endfunction

    // one capture on port a or b, launched by the given ticks
    task automatic op(input logic s, input logic w, input addr_t a,
                      input word_t d, input logic [3:0] l, input logic k0,
                      input logic k1);
        if (s) pb.drive(w, ~w, a, d, l);
        else pa.drive(w, ~w, a, d, l);
        t0 = k0;
        t1 = k1;
        step();
        pa.idle();
        pb.idle();
        t0 = OFF;
        t1 = OFF;
    endtask

    task automatic wr(input logic s, input addr_t a, input word_t d,
                      input logic [3:0] l, input logic k0, input logic k1);
        op(s, ON, a, d, l, k0, k1);
        step();
    endtask

    // read with the same ticks serving as output clock
    task automatic rd(input logic s, input addr_t a, input logic k0,
                      input logic k1, input word_t exp);
        op(s, OFF, a, 36'h0, 4'h0, k0, k1);
        step();
        t0 = k0;
        t1 = k1;
        step();
        t0 = OFF;
        t1 = OFF;
        step();
        chk(s ? "dout_b" : "dout_a", exp, s ? dout_b : dout_a);
    endtask

    task automatic t_indep();
        for (int l = 0; l < 16; l++) begin
            wr(OFF, 7'h05, W1, 4'hf, ON, OFF);
            wr(OFF, 7'h05, W2, 4'(l), ON, OFF);
            rd(OFF, 7'h05, ON, OFF, merge(W1, W2, 4'(l)));
        end
        wr(ON, 7'h7f, W3, 4'hf, OFF, ON);
        rd(ON, 7'h7f, OFF, ON, W3);
        // tick0 belongs to port a only in this mode
        wr(ON, 7'h7f, W1, 4'hf, ON, OFF);
        rd(ON, 7'h7f, OFF, ON, W3);
        $display("test indep done");
    endtask

    task automatic t_enable();
        wr(OFF, 7'h05, W1, 4'hf, ON, OFF);
        en_ia = OFF;
        wr(OFF, 7'h05, W2, 4'hf, ON, OFF);
        en_ia = ON;
        rd(OFF, 7'h05, ON, OFF, W1);
        clr_ia = ON;
        step();
        clr_ia = OFF;
        chk("dout_a", 36'h0, dout_a);
        byp_a = OFF;
        op(OFF, OFF, 7'h05, 36'h0, 4'h0, ON, OFF);
        step();
        chk("dout_a", 36'h0, dout_a);
        t0 = ON;
        step();
        t0 = OFF;
        chk("dout_a", W1, dout_a);
        step();
        $display("test enable and clear done");
    endtask

    task automatic t_inout();
        mode = ram_pkg::MODE_INOUT;
        wr(OFF, 7'h11, W2, 4'hf, ON, OFF);
        op(OFF, OFF, 7'h11, 36'h0, 4'h0, ON, OFF);
        step();
        t0 = ON;
        step();
        t0 = OFF;
        chk("dout_a", W1, dout_a);
        en_oa = OFF;
        t1 = ON;
        step();
        chk("dout_a", W1, dout_a);
        en_oa = ON;
        step();
        t1 = OFF;
        chk("dout_a", W2, dout_a);
        // an input clear must leave the output register alone
        clr_ia = ON;
        step();
        clr_ia = OFF;
        chk("dout_a", W2, dout_a);
        clr_oa = ON;
        step();
        clr_oa = OFF;
        chk("dout_a", 36'h0, dout_a);
        byp_a = ON;
        // simple dual-port: a writes, b reads, inputs on tick0
        sdp = ON;
        wr(ON, 7'h11, W3, 4'hf, ON, OFF);
        rd(ON, 7'h11, ON, OFF, W2);
        rd(OFF, 7'h11, ON, OFF, 36'h0);
        clr_ob = ON;
        step();
        clr_ob = OFF;
        chk("dout_b", 36'h0, dout_b);
        byp_b = OFF;
        en_ob = OFF;
        rd(ON, 7'h11, ON, ON, 36'h0);
        en_ob = ON;
        t1 = ON;
        step();
        t1 = OFF;
        chk("dout_b", W2, dout_b);
        byp_b = ON;
        sdp = OFF;
        $display("test inout done");
    endtask

    task automatic t_rdwr();
        mode = ram_pkg::MODE_RDWR;
        wr(OFF, 7'h20, W1, 4'hf, ON, OFF);
        rd(ON, 7'h20, OFF, ON, W1);
        // the read port may not write here
        wr(ON, 7'h20, W2, 4'hf, OFF, ON);
        rd(ON, 7'h20, OFF, ON, W1);
        wr(OFF, 7'h20, W3, 4'hf, ON, OFF);
        en_ib = OFF;
        rd(ON, 7'h20, OFF, ON, W1);
        en_ib = ON;
        rd(ON, 7'h20, ON, OFF, W1);
        rd(ON, 7'h20, OFF, ON, W3);
        clr_ib = ON;
        step();
        clr_ib = OFF;
        chk("dout_b", 36'h0, dout_b);
        $display("test rdwr done");
    endtask

    task automatic t_single();
        mode = ram_pkg::MODE_SINGLE;
        wr(OFF, 7'h03, W1, 4'hf, ON, OFF);
        wr(ON, 7'h03, W2, 4'hf, OFF, ON);
        rd(OFF, 7'h03, ON, OFF, W1);
        rd(ON, 7'h03, OFF, ON, W2);
        wr(OFF, 7'h43, W3, 4'hf, ON, OFF);
        rd(OFF, 7'h03, ON, OFF, W3);
        rd(ON, 7'h43, OFF, ON, W2);
        // a reset in mid-run zeroes the registers but keeps the array
        rst = ON;
        step();
        rst = OFF;
        chk("dout_a", 36'h0, dout_a);
        chk("dout_b", 36'h0, dout_b);
        rd(OFF, 7'h03, ON, OFF, W3);
        $display("test single done");
    endtask

    initial begin
        repeat (20) @(negedge clk);
        rst = OFF;
        step();
        chk("dout_a", 36'h0, dout_a);
        chk("dout_b", 36'h0, dout_b);
        t_indep();
        t_enable();
        t_inout();
        t_rdwr();
        t_single();
        final_report();
    end

    // run needs about 250 cycles; a hang is cut well beyond that
    initial begin
        repeat (3000) @(posedge clk);
        num_errors++;
        final_report();
    end
endmodule // tb_dual_port_ram_clock_modes
